// file: design/drive_cw_regs.svh
// register offsets, field positions and reset values of the command interpreter
`ifndef DRIVE_CW_REGS_SVH
`define DRIVE_CW_REGS_SVH

// ====================================================================
// register offsets (4-bit address)
`define ADDR_CMD_WORD       4'h0
`define ADDR_STATE_WORD     4'h1
`define ADDR_SPEED_SET      4'h2
`define ADDR_ACT_FREQ       4'h3
`define ADDR_CONFIG         4'h4
`define ADDR_DECODED        4'h5

// ====================================================================
// command word fields
`define CW_REF_LSB          0
`define CW_REF_MSB          1
`define CW_RAMP_NOT_DC      2
`define CW_NO_COAST         3
`define CW_NO_QSTOP         4
`define CW_USE_RAMP         5
`define CW_START            6
`define CW_RESET            7
`define CW_JOG              8
`define CW_RAMP2            9
`define CW_DATA_VALID       10
`define CW_RELAY1           11
`define CW_RELAY2           12
`define CW_SETUP            13
`define CW_REVERSE          15

// ====================================================================
// config register fields
`define CFG_RELAY1_SEL      0
`define CFG_RELAY2_SEL      1
`define CFG_MULTI_SETUP     2
`define CFG_REV_SRC_LSB     3

// ====================================================================
// reset values
`define RST_CMD_WORD        16'h0000
`define RST_SPEED_SET       16'h0000
`define RST_CONFIG          16'h0000
`define SCALE_100_PCT       16'h4000

`endif

// file: design/drive_cw_pkg.sv
// types shared by the command interpreter
package drive_cw_pkg;

  // reversing source selection
  typedef enum logic [1:0] {
    REV_DIGITAL = 2'h0,
    REV_SERIAL  = 2'h1,
    REV_OR      = 2'h2,
    REV_AND     = 2'h3
  } rev_src_t;

  // decoded drive commands
  typedef struct packed {
    logic [1:0] preset_sel;
    logic       dc_brake;
    logic       coast;
    logic       quick_stop;
    logic       freeze;
    logic       ramp_stop;
    logic       trip_reset;
    logic       jog;
    logic       ramp2_sel;
    logic       relay1;
    logic       relay2;
    logic       setup2_sel;
    logic       reverse;
  } drive_cmd_t;

  // drive conditions that build the state word
  typedef struct packed {
    logic ctrl_ready;
    logic drive_ready;
    logic start_enable;
    logic tripped;
    logic error_no_trip;
    logic trip_locked;
    logic warning;
    logic speed_at_ref;
    logic bus_ctrl_ok;
    logic freq_in_limits;
    logic running;
    logic overtemp_stop;
    logic dc_volt_bad;
    logic curr_limit;
    logic thermal_over;
  } drive_cond_t;

endpackage : drive_cw_pkg

// file: design/drive_control_status_words.sv
// fieldbus command word decoder and drive state word builder
`timescale 1ns/1ps
`default_nettype none
`include "drive_cw_regs.svh"

module drive_control_status_words (
  input  wire logic                      clk_sys_i,
  input  wire logic                      resetn_i,
  input  wire logic [3:0]                reg_addr_i,
  input  wire logic [15:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output var  logic [15:0]               reg_rdata_o,
  input  wire drive_cw_pkg::drive_cond_t cond_i,
  input  wire logic                      rev_din_i,
  input  wire logic [15:0]               out_freq_pct_i,
  output var  drive_cw_pkg::drive_cmd_t  cmd_o,
  output var  logic                      relay1_drive_o,
  output var  logic                      relay2_drive_o,
  output var  logic                      relay1_ctrl_o,
  output var  logic                      relay2_ctrl_o,
  output var  logic [15:0]               speed_setpoint_o
);

  // ==================================================================
  // input synchronisers (conditions come from drive logic off-domain)
  drive_cw_pkg::drive_cond_t cond_s1_r;
  drive_cw_pkg::drive_cond_t cond_s2_r;
  logic                      rev_s1_r;
  logic                      rev_s2_r;
  logic [15:0]               freq_s1_r;
  logic [15:0]               freq_s2_r;
  logic [15:0]               freq_hold_r;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cond_s1_r <= '0;
      cond_s2_r <= '0;
      rev_s1_r  <= 1'b0;
      rev_s2_r  <= 1'b0;
      freq_s1_r <= 16'h0000;
      freq_s2_r <= 16'h0000;
    end else begin
      cond_s1_r <= cond_i;
      cond_s2_r <= cond_s1_r;
      rev_s1_r  <= rev_din_i;
      rev_s2_r  <= rev_s1_r;
      freq_s1_r <= out_freq_pct_i;
      freq_s2_r <= freq_s1_r;
    end
  end

  // multi-bit word may tear while it moves; only a word seen twice is kept
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      freq_hold_r <= 16'h0000;
    end else if (freq_s1_r == freq_s2_r) begin
      freq_hold_r <= freq_s2_r;
    end
  end

  // ==================================================================
  // register file
  logic [15:0] cmd_word_r;
  logic [15:0] speed_set_r;
  logic [15:0] config_r;
  logic        reset_prev_r;

  logic wr_cmd;
  logic cmd_valid;
  assign wr_cmd    = reg_wr_i && (reg_addr_i == `ADDR_CMD_WORD);
  assign cmd_valid = reg_wdata_i[`CW_DATA_VALID];

  // invalid words are dropped whole, previous command stays in force
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cmd_word_r <= `RST_CMD_WORD;
    end else if (wr_cmd && cmd_valid) begin
      cmd_word_r <= reg_wdata_i;
    end
  end

  // setpoint is not gated by the valid bit; it is a separate word
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      speed_set_r <= `RST_SPEED_SET;
    end else if (reg_wr_i && (reg_addr_i == `ADDR_SPEED_SET)) begin
      speed_set_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      config_r <= `RST_CONFIG;
    end else if (reg_wr_i && (reg_addr_i == `ADDR_CONFIG)) begin
      config_r <= reg_wdata_i;
    end
  end

  // ==================================================================
  // command decode
  drive_cw_pkg::rev_src_t rev_src;
  logic                   rev_cmd;
  logic                   reset_rise;
  assign rev_src = drive_cw_pkg::rev_src_t'(config_r[`CFG_REV_SRC_LSB +: 2]);

  always_comb begin
    unique case (rev_src)
      drive_cw_pkg::REV_DIGITAL: rev_cmd = rev_s2_r;
      drive_cw_pkg::REV_SERIAL:  rev_cmd = cmd_word_r[`CW_REVERSE];
      drive_cw_pkg::REV_OR:      rev_cmd = cmd_word_r[`CW_REVERSE] | rev_s2_r;
      drive_cw_pkg::REV_AND:     rev_cmd = cmd_word_r[`CW_REVERSE] & rev_s2_r;
    endcase
  end

  // edge is taken between accepted words, so a held one resets once
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      reset_prev_r <= 1'b0;
    end else begin
      reset_prev_r <= cmd_word_r[`CW_RESET];
    end
  end
  assign reset_rise = cmd_word_r[`CW_RESET] & ~reset_prev_r;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cmd_o <= '0;
    end else begin
      cmd_o.preset_sel <= cmd_word_r[`CW_REF_MSB:`CW_REF_LSB];
      cmd_o.dc_brake   <= ~cmd_word_r[`CW_RAMP_NOT_DC];
      cmd_o.coast      <= ~cmd_word_r[`CW_NO_COAST];
      cmd_o.quick_stop <= ~cmd_word_r[`CW_NO_QSTOP];
      cmd_o.freeze     <= ~cmd_word_r[`CW_USE_RAMP];
      // frozen output ignores ramp stop; only coast, quick stop or brake stop it
      cmd_o.ramp_stop  <= ~cmd_word_r[`CW_START] & cmd_word_r[`CW_USE_RAMP];
      cmd_o.trip_reset <= reset_rise;
      cmd_o.jog        <= cmd_word_r[`CW_JOG];
      cmd_o.ramp2_sel  <= cmd_word_r[`CW_RAMP2];
      cmd_o.relay1     <= cmd_word_r[`CW_RELAY1];
      cmd_o.relay2     <= cmd_word_r[`CW_RELAY2];
      cmd_o.setup2_sel <= config_r[`CFG_MULTI_SETUP] & cmd_word_r[`CW_SETUP];
      cmd_o.reverse    <= rev_cmd;
    end
  end

  // bit 14 never decoded
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      relay1_drive_o <= 1'b0;
      relay2_drive_o <= 1'b0;
      relay1_ctrl_o  <= 1'b0;
      relay2_ctrl_o  <= 1'b0;
    end else begin
      relay1_ctrl_o  <= config_r[`CFG_RELAY1_SEL];
      relay2_ctrl_o  <= config_r[`CFG_RELAY2_SEL];
      relay1_drive_o <= config_r[`CFG_RELAY1_SEL] & cmd_word_r[`CW_RELAY1];
      relay2_drive_o <= config_r[`CFG_RELAY2_SEL] & cmd_word_r[`CW_RELAY2];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      speed_setpoint_o <= `RST_SPEED_SET;
    end else begin
      speed_setpoint_o <= speed_set_r;
    end
  end

  // ==================================================================
  // state word
  logic [15:0] state_word;
  always_comb begin
    state_word     = 16'h0000;
    state_word[0]  = cond_s2_r.ctrl_ready & ~cond_s2_r.tripped;
    state_word[1]  = cond_s2_r.drive_ready;
    state_word[2]  = cond_s2_r.start_enable;
    state_word[3]  = cond_s2_r.tripped;
    state_word[4]  = cond_s2_r.error_no_trip;
    state_word[5]  = 1'b0;
    state_word[6]  = cond_s2_r.trip_locked;
    state_word[7]  = cond_s2_r.warning;
    state_word[8]  = cond_s2_r.speed_at_ref;
    state_word[9]  = cond_s2_r.bus_ctrl_ok;
    state_word[10] = cond_s2_r.freq_in_limits;
    state_word[11] = cond_s2_r.running;
    state_word[12] = cond_s2_r.overtemp_stop;
    state_word[13] = cond_s2_r.dc_volt_bad;
    state_word[14] = cond_s2_r.curr_limit;
    state_word[15] = cond_s2_r.thermal_over;
  end

  logic [15:0] decoded_word;
  assign decoded_word = {14'h0000, relay2_drive_o, relay1_drive_o};

  // ==================================================================
  // read port, data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `ADDR_STATE_WORD: reg_rdata_o <= state_word;
        `ADDR_ACT_FREQ:   reg_rdata_o <= freq_hold_r;
        `ADDR_CONFIG:     reg_rdata_o <= config_r;
        `ADDR_DECODED:    reg_rdata_o <= decoded_word;
        default:          reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

endmodule : drive_control_status_words
`default_nettype wire

// file: tb/bus_master_model.sv
// fieldbus master model on the register port
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// master
module bus_master_model (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] rdata_i,
  output var  logic [3:0]  addr_o,
  output var  logic [15:0] wdata_o,
  output var  logic        wr_o,
  output var  logic        rd_o
);
  initial {addr_o, wdata_o, wr_o, rd_o} = '0;
  // released lines show inverted values, never the old ones
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_sys_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_sys_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask : rd
endmodule : bus_master_model
`default_nettype wire

// file: tb/drive_cw_monitor.sv
// port assertions for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "drive_cw_regs.svh"
// ==========================================
// checker
module drive_cw_monitor (
  input wire logic                     clk_sys_i,
  input wire logic                     resetn_i,
  input wire logic [3:0]               reg_addr_i,
  input wire logic [15:0]              reg_wdata_i,
  input wire logic                     reg_wr_i,
  input wire logic                     reg_rd_i,
  input wire logic [15:0]              reg_rdata_o,
  input wire drive_cw_pkg::drive_cmd_t cmd_o,
  input wire logic [15:0]              speed_setpoint_o
);
  logic cw_wr;
  logic rst_req;
  assign cw_wr   = reg_wr_i && reg_addr_i == `ADDR_CMD_WORD;
  assign rst_req = cw_wr && reg_wdata_i[10] && reg_wdata_i[7];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence cw_ok_s;
    cw_wr && reg_wdata_i[10];
  endsequence
  sequence cw_bad_s;
    cw_wr && !reg_wdata_i[10];
  endsequence
  preset_sel_a: assert property (
    cw_ok_s |-> ##2 cmd_o.preset_sel == $past(reg_wdata_i[1:0], 2))
    else $error("preset select wrong");
  stop_bits_a: assert property (
    cw_ok_s |-> ##2 {cmd_o.quick_stop, cmd_o.coast, cmd_o.dc_brake}
      == ~$past(reg_wdata_i[4:2], 2)) else $error("stop bits wrong");
  jog_ramp_a: assert property (
    cw_ok_s |-> ##2 {cmd_o.ramp2_sel, cmd_o.jog} == $past(reg_wdata_i[9:8], 2))
    else $error("jog or ramp pair wrong");
  ignore_word_a: assert property (
    cw_bad_s |-> ##2 $stable(cmd_o.preset_sel) && $stable(cmd_o.jog))
    else $error("invalid word acted on");
  reset_pulse_a: assert property (
    cmd_o.trip_reset |=> !cmd_o.trip_reset) else $error("trip reset too long");
  reset_cause_a: assert property (
    cmd_o.trip_reset |-> $past(rst_req, 2)) else $error("trip reset without request");
  spare_bit_a: assert property (
    reg_rd_i && reg_addr_i == `ADDR_STATE_WORD |=> !reg_rdata_o[5])
    else $error("unused state bit set");
  setpoint_a: assert property (
    reg_wr_i && reg_addr_i == `ADDR_SPEED_SET |-> ##2
      speed_setpoint_o == $past(reg_wdata_i, 2)) else $error("setpoint wrong");
endmodule : drive_cw_monitor
bind drive_control_status_words drive_cw_monitor drive_cw_monitor_inst (.clk_sys_i,
  .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cmd_o,
  .speed_setpoint_o);
`default_nettype wire

// file: tb/tb_drive_control_status_words.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "drive_cw_regs.svh"
// ==========================================
// bench
module tb_drive_control_status_words;
  logic                      clk_sys_i, resetn_i, wr, rd, rev_din, r1d, r2d, r1c, r2c;
  logic [3:0]                addr;
  logic [15:0]               wdata, rdata, rv, freq, spd, keep;
  drive_cw_pkg::drive_cond_t cond;
  drive_cw_pkg::drive_cmd_t  cmd;
  int                        err_count, samples_checked, pulses;
  logic [15:0] cw_tab [7] = '{16'h0478, 16'h0474, 16'h046c, 16'h045c, 16'h043c, 16'h041c,
                              16'h077c};
  logic [6:0]  ex_tab [7] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h08, 7'h03};
  logic [15:0] rc_cfg [6] = '{16'h00, 16'h04, 16'h08, 16'h10, 16'h18, 16'h18};
  logic [1:0]  rc_exp [6] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h0, 2'h1};
  drive_control_status_words drive_control_status_words_inst (.clk_sys_i, .resetn_i,
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .cond_i(cond), .rev_din_i(rev_din), .out_freq_pct_i(freq),
    .cmd_o(cmd), .relay1_drive_o(r1d), .relay2_drive_o(r2d), .relay1_ctrl_o(r1c),
    .relay2_ctrl_o(r2c), .speed_setpoint_o(spd));
  bus_master_model bus_master_model_inst (.clk_sys_i, .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // command word write, then room for register and output flop
  task automatic cw(input logic [15:0] d);
    bus_master_model_inst.wr(`ADDR_CMD_WORD, d);
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask : cw
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) if (resetn_i && cmd.trip_reset) pulses++;
  initial begin
    #200us;
    err_count++;
    tally_and_finish();
  end
  initial begin
    {resetn_i, rev_din, cond, err_count, samples_checked, pulses} = '0;
    freq = 16'hc000;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cw(16'h0478 | 16'(i));
      check("preset", {14'h0, cmd.preset_sel}, 16'(i));
    end
    for (int i = 0; i < 7; i++) begin
      cw(cw_tab[i]);
      check("stops", {9'h0, cmd.dc_brake, cmd.coast, cmd.quick_stop, cmd.freeze,
        cmd.ramp_stop, cmd.jog, cmd.ramp2_sel}, {9'h0, ex_tab[i]});
    end
    keep = 16'(cmd);
    cw(16'h0083);
    check("ignored", 16'(cmd), keep);
    pulses = 0;
    cw(16'h0480);
    cw(16'h0480);
    cw(16'h0400);
    cw(16'h0480);
    check("resets", 16'(pulses), 16'h0002);
    for (int c = 0; c < 4; c++) begin
      bus_master_model_inst.wr(`ADDR_CONFIG, 16'(c));
      cw(16'h1c00);
      check("relay", {12'h0, r1d, r2d, r1c, r2c}, {12'h0, c[0], c[1], c[0], c[1]});
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys_i);
      rev_din <= (i == 5);
      bus_master_model_inst.wr(`ADDR_CONFIG, rc_cfg[i]);
      cw(16'he400);
      check("setup_rev", {14'h0, cmd.setup2_sel, cmd.reverse}, {14'h0, rc_exp[i]});
    end
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys_i);
      cond <= (k == 15) ? 15'h4800 : 15'(15'h4000 >> k);
      repeat (4) @(posedge clk_sys_i);
      bus_master_model_inst.rd(`ADDR_STATE_WORD, rv);
      check("state", rv, (k == 15) ? 16'h0008 : (k < 5) ? 16'h1 << k : 16'h1 << (k + 1));
    end
    bus_master_model_inst.wr(`ADDR_SPEED_SET, 16'h4000);
    bus_master_model_inst.rd(`ADDR_ACT_FREQ, rv);
    check("act_freq", rv, 16'hc000);
    check("setpoint", spd, 16'h4000);
    bus_master_model_inst.rd(4'hf, rv);
    check("unmapped", rv, 16'h0000);
    tally_and_finish();
  end
endmodule : tb_drive_control_status_words
`default_nettype wire
